// ### dma_page_command_status.v
// limitations: channel 4 has no page port, so its address output always
// carries a zero page. reserved command bits are stored but never used,
// so a careless write there has no effect on arbitration or enabling.
`timescale 1ns/100ps
`include "dma_page_map.vh"

module dma_page_command_status (
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    input  wire [7:0]  i_io_addr,
    input  wire        i_io_wr,
    input  wire        i_io_rd,
    input  wire [7:0]  i_io_wdata,
    input  wire [7:0]  i_chan_req,
    input  wire [7:0]  i_soft_req,
    input  wire [7:0]  i_count_step,
    input  wire [127:0] i_cur_count,
    input  wire [127:0] i_cur_addr,
    input  wire [7:0]  i_tc_clear,
    input  wire        i_xfer_busy,
    output reg  [7:0]  o_io_rdata,
    output reg         o_io_hit,
    output reg  [191:0] o_xfer_addr,
    output reg  [7:0]  o_tc,
    output reg  [7:0]  o_req_pending,
    output reg         o_low_rotate,
    output reg         o_high_rotate,
    output reg         o_low_enable,
    output reg         o_high_enable
);

////////////////////////////////////////////////////////////////////////
reg  [7:0] page [0:7];
reg  [7:0] low_cmd;
reg  [7:0] high_cmd;
wire [7:0] req_any = i_chan_req | i_soft_req;

// returns channel number plus a hit flag in bit 3
function [3:0] page_decode;
    input [7:0] a;
    begin
        case (a)
            `PORT_PAGE_CH0: page_decode = 4'h8;
            `PORT_PAGE_CH1: page_decode = 4'h9;
            `PORT_PAGE_CH2: page_decode = 4'hA;
            `PORT_PAGE_CH3: page_decode = 4'hB;
            `PORT_PAGE_CH5: page_decode = 4'hD;
            `PORT_PAGE_CH6: page_decode = 4'hE;
            `PORT_PAGE_CH7: page_decode = 4'hF;
            default:        page_decode = 4'h0;
        endcase
    end
endfunction

wire [3:0] wr_dec = page_decode(i_io_addr);

////////////////////////////////////////////////////////////////////////
// page registers: only software writes change them
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : g_page
        always @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                page[g] <= `PAGE_RESET_VALUE;
            end else if (i_io_wr && wr_dec[3] && wr_dec[2:0] == g) begin
                page[g] <= i_io_wdata;
            end
        end

        // terminal count: hardware set wins over clear, so a wrap that
        // lands in the same cycle as a software clear is never lost
        always @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                o_tc[g] <= 1'b0;
            end else if (i_count_step[g] &&
                         i_cur_count[16*g +: 16] == 16'h0000) begin
                o_tc[g] <= 1'b1;
            end else if (i_tc_clear[g]) begin
                o_tc[g] <= 1'b0;
            end
        end

        // 8-bit channels pass the address, 16-bit ones shift it
        always @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                o_xfer_addr[24*g +: 24] <= 24'h00_0000;
            end else if (g >= 5) begin
                o_xfer_addr[24*g +: 24] <=
                    {page[g], i_cur_addr[16*g +: 15], 1'b0};
            end else begin
                o_xfer_addr[24*g +: 24] <=
                    {page[g], i_cur_addr[16*g +: 16]};
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// command registers (reserved bits stored but unused)
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        low_cmd <= `CMD_RESET_VALUE;
    end else if (i_io_wr && i_io_addr == `PORT_LOW_CMD) begin
        low_cmd <= i_io_wdata;
    end
end

always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        high_cmd <= `CMD_RESET_VALUE;
    end else if (i_io_wr && i_io_addr == `PORT_HIGH_CMD) begin
        high_cmd <= i_io_wdata;
    end
end

// a disabled upper group starves the lower one, which borrows channel 4
// to reach the bus
wire next_high_enable = !high_cmd[`CMD_DISABLE_BIT];
wire next_low_enable  = !low_cmd[`CMD_DISABLE_BIT] &&
                        next_high_enable;

// arbitration settings only move while no transfer runs, so a
// transfer in flight keeps the policy it was started with
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_low_rotate  <= 1'b0;
        o_high_rotate <= 1'b0;
        o_low_enable  <= 1'b1;
        o_high_enable <= 1'b1;
    end else if (!i_xfer_busy) begin
        o_low_rotate  <= low_cmd[`CMD_ROTATE_BIT];
        o_high_rotate <= high_cmd[`CMD_ROTATE_BIT];
        o_high_enable <= next_high_enable;
        o_low_enable  <= next_low_enable;
    end
end

////////////////////////////////////////////////////////////////////////
// pending requests; channel 4 reflects the cascade
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_req_pending <= 8'h00;
    end else begin
        o_req_pending <= {req_any[7:5], |req_any[3:0],
                          req_any[3:0]};
    end
end

////////////////////////////////////////////////////////////////////////
// status bytes as the host sees them: requests high, terminal counts low
wire [7:0] low_state  = {o_req_pending[3:0], o_tc[3:0]};
wire [7:0] high_state = {o_req_pending[7:4], o_tc[7:4]};

////////////////////////////////////////////////////////////////////////
// read port: decode here, register below so the data bus is clean
reg  [7:0] next_io_rdata;
reg        next_io_hit;

// reads have no side effects, so the host may poll status freely
always @* begin
    next_io_rdata = 8'h00;
    next_io_hit   = 1'b0;
    if (i_io_rd) begin
        if (wr_dec[3]) begin
            next_io_rdata = page[wr_dec[2:0]];
            next_io_hit   = 1'b1;
        end else if (i_io_addr == `PORT_LOW_CMD) begin
            next_io_rdata = low_state;
            next_io_hit   = 1'b1;
        end else if (i_io_addr == `PORT_HIGH_CMD) begin
            next_io_rdata = high_state;
            next_io_hit   = 1'b1;
        end
    end
end

// unmapped reads return zero and no hit, never stale data
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_io_rdata <= 8'h00;
        o_io_hit   <= 1'b0;
    end else begin
        o_io_rdata <= next_io_rdata;
        o_io_hit   <= next_io_hit;
    end
end

endmodule

// ### dma_page_command_status_asserts.sv
`timescale 1ns/100ps
module dma_pcs_asserts (
    input wire         i_ref_clk,
    input wire         i_rst_b,
    input wire [7:0]   i_io_addr,
    input wire         i_io_wr,
    input wire         i_io_rd,
    input wire [7:0]   i_io_wdata,
    input wire [7:0]   i_chan_req,
    input wire [7:0]   i_soft_req,
    input wire [127:0] i_cur_addr,
    input wire         i_xfer_busy,
    input wire [7:0]   o_io_rdata,
    input wire         o_io_hit,
    input wire [191:0] o_xfer_addr,
    input wire [7:0]   o_req_pending,
    input wire         o_high_rotate,
    input wire         o_low_enable,
    input wire         o_high_enable
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////
    sequence seq_off;
        i_io_wr && i_io_addr == 8'hd0 && i_io_wdata[2] ##1 !i_xfer_busy;
    endsequence
    chk_group_off: assert property (seq_off |=>
        !o_high_enable && !o_low_enable) else $error("group still on");
    chk_read_hit: assert property (i_io_rd && i_io_addr == 8'h87
        |=> o_io_hit) else $error("page read missed");
    chk_unmapped_quiet: assert property (i_io_rd && i_io_addr == 8'h00
        |=> !o_io_hit && o_io_rdata == 8'h00) else $error("unmapped hit");
    // a page may only move after a port write, never with the address
    chk_page_static: assert property (!i_io_wr ##1 !i_io_wr
        |=> $stable(o_xfer_addr[23:16])) else $error("page moved");
    chk_pend_map: assert property (1'b1 |=> o_req_pending[3:0] ==
        $past(i_chan_req[3:0] | i_soft_req[3:0])) else $error("pending");
    chk_pend_or: assert property (1'b1 |=> o_req_pending[4] ==
        $past(|(i_chan_req[3:0] | i_soft_req[3:0]))) else $error("cascade");
    chk_busy_hold: assert property (i_xfer_busy
        |=> $stable(o_high_rotate)) else $error("changed mid transfer");
    chk_addr_shift: assert property (1'b1 |=> o_xfer_addr[135:120] ==
        $past({i_cur_addr[94:80], 1'b0})) else $error("word address");
endmodule
bind dma_page_command_status dma_pcs_asserts u_dma_pcs_asserts (.*);

// ### dma_page_command_status_tb.sv
`timescale 1ns/100ps
module dma_page_command_status_tb;
    reg i_ref_clk = 0, i_rst_b = 0, i_io_wr = 0, i_io_rd = 0;
    reg i_xfer_busy = 0;
    reg [7:0] i_io_addr = 0, i_io_wdata = 0, i_count_step = 0;
    reg [7:0] i_tc_clear = 0, hw = 0, sw = 0;
    reg [127:0] i_cur_count = 0, i_cur_addr = {8{16'h8421}};
    wire [7:0] i_chan_req, i_soft_req, o_io_rdata, o_tc, o_req_pending;
    wire [191:0] o_xfer_addr;
    wire o_io_hit, o_low_rotate, o_high_rotate, o_low_enable, o_high_enable;
    wire [7:0] cfg = {4'h0, o_low_enable, o_high_enable,
        o_high_rotate, o_low_rotate};
    integer num_errors = 0, checks = 0, cyc = 0, k;
    reg [15:0] rows [0:6] = '{16'h8711, 16'h8322, 16'h8133, 16'h8244,
        16'h8b55, 16'h8966, 16'h8a77};
    dma_page_command_status u_dma_page_command_status (.*);
    io_requester u_io_requester (.i_clk(i_ref_clk), .i_hw(hw), .i_sw(sw),
        .o_hw(i_chan_req), .o_sw(i_soft_req));
    initial forever #5 i_ref_clk = ~i_ref_clk;
    ////////////////////////////////////////////////////////////////
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            give_verdict;
        end
    end
    task chk(input [7:0] s, input [7:0] e, input string n);
        checks = checks + 1;
        if (s !== e) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // strobe lasts one cycle; read data is valid at the closing negedge
    task io(input w, input [7:0] a, input [7:0] d);
        @(negedge i_ref_clk);
        {i_io_wr, i_io_rd, i_io_addr, i_io_wdata} = {w, !w, a, d};
        @(negedge i_ref_clk);
        {i_io_wr, i_io_rd} = 2'b00;
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge i_ref_clk);
        i_rst_b = 1;
        chk(cfg, 8'h0c, "reset");
        chk(o_io_rdata | o_tc | {7'h0, o_io_hit}, 8'h00, "rst out");
        $display("test reset done");
        for (k = 0; k < 7; k = k + 1) io(1, rows[k][15:8], rows[k][7:0]);
        for (k = 0; k < 7; k = k + 1) begin
            io(0, rows[k][15:8], 8'h00);
            chk(o_io_rdata, rows[k][7:0], "page");
            chk({7'h0, o_io_hit}, 8'h01, "hit");
            chk(o_xfer_addr[24*(k<4?k:k+1)+16 +: 8], rows[k][7:0], "addr");
        end
        $display("test pages done");
        io(0, 8'h00, 8'h00);
        chk(o_io_rdata | {7'h0, o_io_hit}, 8'h00, "unmapped");
        hw = 8'h21;
        sw = 8'h04;
        i_count_step = 8'h42;
        @(negedge i_ref_clk);
        i_count_step = 8'h00;
        repeat (2) @(negedge i_ref_clk);
        io(0, 8'h08, 8'h00);
        chk(o_io_rdata, 8'h52, "low state");
        io(0, 8'hd0, 8'h00);
        chk(o_io_rdata, 8'h34, "high state");
        $display("test state done");
        // busy holds the old setup; the rewrite after it hits the idle case
        i_xfer_busy = 1;
        io(1, 8'hd0, 8'h14);
        repeat (2) @(negedge i_ref_clk);
        chk(cfg, 8'h0c, "busy");
        i_xfer_busy = 0;
        io(1, 8'hd0, 8'h14);
        repeat (2) @(negedge i_ref_clk);
        chk(cfg, 8'h02, "off");
        io(1, 8'h08, 8'h10);
        io(1, 8'hd0, 8'h00);
        repeat (2) @(negedge i_ref_clk);
        chk(cfg, 8'h0d, "on");
        io(1, 8'h08, 8'h04);
        repeat (2) @(negedge i_ref_clk);
        chk(cfg, 8'h04, "low off");
        $display("test command done");
        // clear ch1; on ch6 a wrap meets a clear and the set must win
        i_count_step = 8'h40;
        i_tc_clear = 8'h42;
        @(negedge i_ref_clk);
        {i_count_step, i_tc_clear} = 16'h0000;
        chk(o_tc, 8'h40, "tc clear");
        i_cur_count[47:32] = 16'h0001;
        i_count_step = 8'h04;
        @(negedge i_ref_clk);
        i_count_step = 8'h00;
        chk(o_tc, 8'h40, "no wrap");
        $display("test terminal count done");
        i_rst_b = 0;
        @(negedge i_ref_clk);
        i_rst_b = 1;
        chk(cfg, 8'h0c, "rerun reset");
        io(0, 8'h87, 8'h00);
        chk(o_io_rdata, 8'h00, "page reset");
        $display("test second reset done");
        give_verdict;
    end
endmodule

// ### dma_page_map.vh
`ifndef DMA_PAGE_MAP_VH
`define DMA_PAGE_MAP_VH

// byte port addresses
`define PORT_LOW_CMD      8'h08
`define PORT_HIGH_CMD     8'hD0
`define PORT_PAGE_CH0     8'h87
`define PORT_PAGE_CH1     8'h83
`define PORT_PAGE_CH2     8'h81
`define PORT_PAGE_CH3     8'h82
`define PORT_PAGE_CH5     8'h8B
`define PORT_PAGE_CH6     8'h89
`define PORT_PAGE_CH7     8'h8A

// command fields
`define CMD_ROTATE_BIT    4
`define CMD_DISABLE_BIT   2
`define CMD_RESET_VALUE   8'h00

// terminal count wrap value and page reset value
`define COUNT_WRAP        16'hFFFF
`define PAGE_RESET_VALUE  8'h00

`endif

// ### io_requester.sv
`timescale 1ns/100ps
// peripherals and software raise requests on the falling edge
module io_requester (
    input  wire       i_clk,
    input  wire [7:0] i_hw,
    input  wire [7:0] i_sw,
    output reg  [7:0] o_hw,
    output reg  [7:0] o_sw
);
    always @(negedge i_clk) begin
        o_hw <= i_hw;
        o_sw <= i_sw;
    end
endmodule
